// ### rtl/tcsp_defines.svh
// Register map, field positions, reset values and counts of the shared-prescaler timer.
`ifndef TCSP_DEFINES_SVH
`define TCSP_DEFINES_SVH

// ********************************************************************
// Register indices (byte address is four times the index).
// ********************************************************************
`define TCSP_IDX_COUNT 10'h001
`define TCSP_IDX_OPTION 10'h081
`define TCSP_IDX_INTCTL 10'h00B

// ********************************************************************
// Reset values.
// ********************************************************************
`define TCSP_COUNT_RESET 8'h00
`define TCSP_OPTION_RESET 8'hFF
`define TCSP_INTCTL_RESET 8'h00
`define TCSP_PRESC_CLEAR 8'h00
`define TCSP_SRC_PREV_RESET 1'b1

// ********************************************************************
// Field positions.
// ********************************************************************
`define TCSP_OPT_RATIO_HI 2
`define TCSP_OPT_RATIO_LO 0
`define TCSP_OPT_ASSIGN_BIT 3
`define TCSP_OPT_EDGE_BIT 4
`define TCSP_OPT_SOURCE_BIT 5
`define TCSP_INT_FLAG_BIT 2
`define TCSP_INT_ENABLE_BIT 5
`define TCSP_SEL_LOW_LANE 0

// ********************************************************************
// Counts and special values.
// ********************************************************************
`define TCSP_INHIBIT_CYCLES 2'h2
`define TCSP_INHIBIT_NONE 2'h0
`define TCSP_INHIBIT_STEP 2'h1
`define TCSP_COUNT_MAX 8'hFF
`define TCSP_COUNT_STEP 8'h01
`define TCSP_RATIO_UNSCALED 3'h0
`define TCSP_RATIO_STEP 3'h1
`define TCSP_READ_ZERO 32'h0000_0000

`endif

// ### rtl/tcsp_pkg.sv
// Types shared by the shared-prescaler timer modules.
package tcsp_pkg;

   // ********************************************************************
   // Clock source and prescaler owner encodings of the option register.
   // ********************************************************************
   typedef enum logic {
      TCSP_SRC_CYCLE = 1'b0,
      TCSP_SRC_PIN = 1'b1
   } tcsp_src_t;

   typedef enum logic {
      TCSP_OWNER_TIMER = 1'b0,
      TCSP_OWNER_WATCHDOG = 1'b1
   } tcsp_owner_t;

endpackage

// ### rtl/tcsp_sync.sv
// Three-stage synchroniser that accepts a pin change once the last two stages agree.
`timescale 1ns/10ps
module tcsp_sync (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic d_in,
   output logic q_out
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // ********************************************************************
   // Shift chain; only the second stage looks at the first.
   // ********************************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else if (ce_in) begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Accept a level only when two settled stages agree, which rejects a late-resolving sample.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q_out <= 1'b0;
      end else if (ce_in && (s2_reg == s3_reg)) begin
         q_out <= s3_reg;
      end
   end

endmodule

// ### rtl/tcsp_prescaler.sv
// Divider counter shared between the timer and the watchdog; not visible to software.
`timescale 1ns/10ps
`include "tcsp_defines.svh"
module tcsp_prescaler #(
   parameter int WIDTH = 8
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic clear_in,
   input wire logic tick_in,
   output logic [WIDTH-1:0] count_out
);

   // ********************************************************************
   // Binary divider: each bit is a square wave at half the rate of the bit below.
   // ********************************************************************
   // A clear wins over a tick so the divider restarts from a known phase.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         count_out <= WIDTH'(`TCSP_PRESC_CLEAR);
      end else if (ce_in) begin
         if (clear_in) begin
            count_out <= WIDTH'(`TCSP_PRESC_CLEAR);
         end else if (tick_in) begin
            count_out <= count_out + WIDTH'(1);
         end
      end
   end

endmodule

// ### rtl/tcsp_top.sv
// Eight-bit timer/counter with a prescaler shared with the watchdog, on a Wishbone slave.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
`include "tcsp_defines.svh"
module tcsp_top #(
   parameter int ADR_W = 10,
   parameter int PRESC_W = 8
) (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [ADR_W+1:2] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic EXT_COUNT_PIN_IN,
   input wire logic SLEEP_IN,
   input wire logic WATCHDOG_TICK_IN,
   input wire logic WATCHDOG_CLEAR_INSTR_IN,
   output logic WATCHDOG_TIMEOUT_OUT,
   output logic OVERFLOW_IRQ_OUT
);

   // ********************************************************************
   // Declarations.
   // ********************************************************************
   logic [7:0] count_reg;
   logic [7:0] option_reg;
   logic [7:0] intctl_reg;
   logic [7:0] intctl_next;
   logic [1:0] inhibit_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic pin_level;
   logic src_level;
   logic src_prev_reg;
   logic src_rise;
   logic [PRESC_W-1:0] presc_cnt;
   logic presc_tick;
   logic presc_clear;
   logic [2:0] ratio;
   logic [2:0] tap_idx;
   logic tap_level;
   logic tap_prev_reg;
   logic tap_rise;
   logic wdt_pulse;
   logic wdt_pulse_reg;
   logic timer_evt;
   logic inc;
   logic overflow_set;
   logic req;
   logic wr_commit;
   logic wr_count;
   logic wr_option;
   logic wr_intctl;
   tcsp_pkg::tcsp_src_t src_sel;
   tcsp_pkg::tcsp_owner_t owner;

   // ********************************************************************
   // Helper functions.
   // ********************************************************************
   // Picks one bit of the prescaler; shared by the timer and watchdog taps.
   function automatic logic tcsp_tap(input logic [PRESC_W-1:0] cnt, input logic [2:0] idx);
      tcsp_tap = cnt[idx];
   endfunction

   // Matches a word index against one register index.
   function automatic logic tcsp_hit(input logic [ADR_W-1:0] adr, input logic [9:0] idx);
      tcsp_hit = (adr == ADR_W'(idx));
   endfunction

   // ********************************************************************
   // Option field decode.
   // ********************************************************************
   // Field decode of the option register into the block's steering signals.
   assign ratio = option_reg[`TCSP_OPT_RATIO_HI:`TCSP_OPT_RATIO_LO];
   assign src_sel = tcsp_pkg::tcsp_src_t'(option_reg[`TCSP_OPT_SOURCE_BIT]);
   assign owner = tcsp_pkg::tcsp_owner_t'(option_reg[`TCSP_OPT_ASSIGN_BIT]);

   // ********************************************************************
   // Wishbone classic slave.
   // ********************************************************************
   // A request is new while ack has not yet been given for it.
   assign req = WB_CYC_IN && WB_STB_IN && !ack_reg;
   // Writes land at the edge where the master samples ack, so a held request writes once.
   assign wr_commit = ack_reg && WB_CYC_IN && WB_STB_IN && WB_WE_IN
                      && WB_SEL_IN[`TCSP_SEL_LOW_LANE];
   assign wr_count = wr_commit && tcsp_hit(WB_ADR_IN, `TCSP_IDX_COUNT);
   assign wr_option = wr_commit && tcsp_hit(WB_ADR_IN, `TCSP_IDX_OPTION);
   assign wr_intctl = wr_commit && tcsp_hit(WB_ADR_IN, `TCSP_IDX_INTCTL);

   // Ack follows each request by one cycle and drops in the cycle after.
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         ack_reg <= 1'b0;
      end else if (CE_IN) begin
         ack_reg <= req;
      end
   end

   // Read data is captured with the request; unmapped words read as zero.
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         rdata_reg <= `TCSP_READ_ZERO;
      end else if (CE_IN && req) begin
         if (tcsp_hit(WB_ADR_IN, `TCSP_IDX_COUNT)) begin
            rdata_reg <= {24'h000000, count_reg};
         end else if (tcsp_hit(WB_ADR_IN, `TCSP_IDX_OPTION)) begin
            rdata_reg <= {24'h000000, option_reg};
         end else if (tcsp_hit(WB_ADR_IN, `TCSP_IDX_INTCTL)) begin
            rdata_reg <= {24'h000000, intctl_reg};
         end else begin
            rdata_reg <= `TCSP_READ_ZERO;
         end
      end
   end

   assign WB_ACK_OUT = ack_reg;
   assign WB_DAT_OUT = rdata_reg;

   // ********************************************************************
   // Configuration registers.
   // ********************************************************************
   // Option register; the two top bits are plain storage for neighbouring functions.
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         option_reg <= `TCSP_OPTION_RESET;
      end else if (CE_IN && wr_option) begin
         option_reg <= WB_DAT_IN[7:0];
      end
   end

   // The overflow flag is set by hardware and only software clears it; a set wins a clear.
   always_comb begin
      intctl_next = intctl_reg;
      if (wr_intctl) begin
         intctl_next = WB_DAT_IN[7:0];
      end
      if (overflow_set) begin
         intctl_next[`TCSP_INT_FLAG_BIT] = 1'b1;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         intctl_reg <= `TCSP_INTCTL_RESET;
      end else if (CE_IN) begin
         intctl_reg <= intctl_next;
      end
   end

   // The interrupt is a level that follows the flag through its mask.
   assign OVERFLOW_IRQ_OUT = intctl_reg[`TCSP_INT_FLAG_BIT]
                             && intctl_reg[`TCSP_INT_ENABLE_BIT];

   // ********************************************************************
   // External count pin.
   // ********************************************************************
   tcsp_sync u_pin_sync (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .ce_in(CE_IN),
      .d_in(EXT_COUNT_PIN_IN),
      .q_out(pin_level)
   );

   // Inverting the level turns a falling pin edge into a rising one.
   assign src_level = pin_level ^ option_reg[`TCSP_OPT_EDGE_BIT];
   assign src_rise = src_level && !src_prev_reg;

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         src_prev_reg <= `TCSP_SRC_PREV_RESET; // Reset option inverts an idle low pin to high.
      end else if (CE_IN) begin
         src_prev_reg <= src_level;
      end
   end

   // ********************************************************************
   // Shared prescaler.
   // ********************************************************************
   // The owner feeds the divider; the timer's feed stops during sleep, the watchdog's does not.
   always_comb begin
      if (owner == tcsp_pkg::TCSP_OWNER_WATCHDOG) begin
         presc_tick = WATCHDOG_TICK_IN;
      end else if (SLEEP_IN) begin
         presc_tick = 1'b0;
      end else if (src_sel == tcsp_pkg::TCSP_SRC_PIN) begin
         presc_tick = src_rise;
      end else begin
         presc_tick = 1'b1;
      end
   end

   // Each owner clears the divider through its own clearing action only.
   assign presc_clear = (wr_count && owner == tcsp_pkg::TCSP_OWNER_TIMER)
                        || (WATCHDOG_CLEAR_INSTR_IN
                            && owner == tcsp_pkg::TCSP_OWNER_WATCHDOG);

   tcsp_prescaler #(
      .WIDTH(PRESC_W)
   ) u_prescaler (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .ce_in(CE_IN),
      .clear_in(presc_clear),
      .tick_in(presc_tick),
      .count_out(presc_cnt)
   );

   // Timer ratio r takes bit r (1:2 at 000); the watchdog is one octave finer (1:1 at 000).
   assign tap_idx = (owner == tcsp_pkg::TCSP_OWNER_WATCHDOG) ? (ratio - `TCSP_RATIO_STEP)
                                                             : ratio;
   assign tap_level = tcsp_tap(presc_cnt, tap_idx);
   // Edge sampling of the prescaler output turns each rise of the tapped bit into a one-cycle event.
   assign tap_rise = tap_level && !tap_prev_reg;

   // A cleared divider brings the tap low, so no false edge follows a clear.
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         tap_prev_reg <= 1'b0;
      end else if (CE_IN) begin
         tap_prev_reg <= tap_level;
      end
   end

   // ********************************************************************
   // Watchdog postscaler output.
   // ********************************************************************
   // Without the prescaler, or at ratio 1:1, the watchdog tick passes straight through.
   always_comb begin
      if (owner == tcsp_pkg::TCSP_OWNER_TIMER) begin
         wdt_pulse = WATCHDOG_TICK_IN;
      end else if (ratio == `TCSP_RATIO_UNSCALED) begin
         wdt_pulse = WATCHDOG_TICK_IN;
      end else begin
         wdt_pulse = tap_rise;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         wdt_pulse_reg <= 1'b0;
      end else if (CE_IN) begin
         wdt_pulse_reg <= wdt_pulse;
      end
   end

   assign WATCHDOG_TIMEOUT_OUT = wdt_pulse_reg;

   // ********************************************************************
   // Timer count.
   // ********************************************************************
   // Unscaled timer counts every cycle or every selected pin edge; scaled counts tap edges.
   always_comb begin
      if (owner == tcsp_pkg::TCSP_OWNER_TIMER) begin
         timer_evt = tap_rise;
      end else if (src_sel == tcsp_pkg::TCSP_SRC_PIN) begin
         timer_evt = src_rise;
      end else begin
         timer_evt = 1'b1;
      end
   end

   // Sleep and the post-write window both hold the count.
   assign inc = timer_evt && !SLEEP_IN && (inhibit_reg == `TCSP_INHIBIT_NONE)
                && !wr_count;
   assign overflow_set = inc && (count_reg == `TCSP_COUNT_MAX);

   // A write arms the two-cycle hold; software compensates by writing an adjusted value.
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         inhibit_reg <= `TCSP_INHIBIT_NONE;
      end else if (CE_IN) begin
         if (wr_count) begin
            inhibit_reg <= `TCSP_INHIBIT_CYCLES;
         end else if (inhibit_reg != `TCSP_INHIBIT_NONE) begin
            inhibit_reg <= inhibit_reg - `TCSP_INHIBIT_STEP;
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         count_reg <= `TCSP_COUNT_RESET;
      end else if (CE_IN) begin
         if (wr_count) begin
            count_reg <= WB_DAT_IN[7:0];
         end else if (inc) begin
            count_reg <= count_reg + `TCSP_COUNT_STEP;
         end
      end
   end

   // ********************************************************************
   // Assertions.
   // ********************************************************************
   default clocking tcsp_cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN || !CE_IN);

   sequence write_then_quiet_s;
      wr_count ##1 !wr_count ##1 !wr_count;
   endsequence

   sequence unscaled_cycle_s;
      owner == tcsp_pkg::TCSP_OWNER_WATCHDOG && src_sel == tcsp_pkg::TCSP_SRC_CYCLE
      && !SLEEP_IN && inhibit_reg == `TCSP_INHIBIT_NONE && !wr_count;
   endsequence

   ack_single_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack stayed high for two cycles");

   count_write_load_a: assert property (wr_count |=> count_reg == $past(WB_DAT_IN[7:0]))
      else $error("count did not take the written value");

   write_hold_a: assert property (write_then_quiet_s |=> count_reg == $past(count_reg, 2))
      else $error("count moved within two cycles of a write");

   timer_step_a: assert property (unscaled_cycle_s |=> count_reg == $past(count_reg)
                                  + `TCSP_COUNT_STEP)
      else $error("unscaled timer did not step by one");

   edge_count_a: assert property (owner == tcsp_pkg::TCSP_OWNER_WATCHDOG
                                  && src_sel == tcsp_pkg::TCSP_SRC_PIN && !src_rise
                                  && !wr_count |=> $stable(count_reg))
      else $error("counter mode moved without a pin edge");

   sleep_freeze_a: assert property (SLEEP_IN && !wr_count |=> $stable(count_reg))
      else $error("count moved during sleep");

   overflow_flag_a: assert property (inc && count_reg == `TCSP_COUNT_MAX
                                     |=> intctl_reg[`TCSP_INT_FLAG_BIT]
                                     && count_reg == `TCSP_COUNT_RESET)
      else $error("wrap did not set the overflow flag");

   irq_mask_a: assert property (!intctl_reg[`TCSP_INT_ENABLE_BIT]
                                |-> !OVERFLOW_IRQ_OUT)
      else $error("masked overflow interrupt was raised");

   presc_write_clear_a: assert property (wr_count && owner == tcsp_pkg::TCSP_OWNER_TIMER
                                         |=> presc_cnt == PRESC_W'(`TCSP_PRESC_CLEAR))
      else $error("count write did not clear the prescaler");

   presc_wdt_clear_a: assert property (WATCHDOG_CLEAR_INSTR_IN
                                       && owner == tcsp_pkg::TCSP_OWNER_WATCHDOG
                                       |=> presc_cnt == PRESC_W'(`TCSP_PRESC_CLEAR))
      else $error("watchdog clear did not clear the prescaler");

endmodule

// ### tb/tcsp_pin_source.sv
// Behavioural source that drives the external count pin.
`timescale 1ns/10ps
module tcsp_pin_source (
   input wire logic clk_in,
   output logic pin_out
);
   // ****
   // Pin stimulus
   // ****
   // The pin idles low and is always driven, like a push-pull source.
   initial begin
      pin_out = 1'h0;
   end
   // Each level stands two to seven clocks, so both prompt and slow edges are seen.
   task automatic toggles(input int n);
      int hold;
      for (int i = 0; i < n; i++) begin
         hold = 2 + ($urandom % 6);
         @(posedge clk_in);
         pin_out <= ~pin_out;
         repeat (hold - 1) @(posedge clk_in);
      end
   endtask
endmodule

// ### tb/timer_counter_shared_prescaler_bench.sv
// Self-checking bench for the shared-prescaler timer and its pin source.
`timescale 1ns/10ps
`include "tcsp_defines.svh"
module timer_counter_shared_prescaler_bench;
   // ****
   // Signals
   // ****
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic sleep = 1'h0;
   logic wd_tick = 1'h0;
   logic wd_clr = 1'h0;
   logic cyc = 1'h0;
   logic stb = 1'h0;
   logic we = 1'h0;
   logic [9:0] adr = 10'h000;
   logic [31:0] dat_w = 32'h0;
   logic [3:0] sel = 4'h0;
   logic ce = 1'h1;
   logic [31:0] dat_r;
   logic ack;
   logic pin;
   logic wd_to;
   logic irq;
   logic [31:0] q;
   logic [31:0] q2;
   logic [7:0] dq;
   logic [7:0] v;
   int failures = 0;
   int comparisons = 0;
   int to_n = 0;
   int cyc_n = 0;
   int t_take;
   int t1;
   int seed_v;
   int n;
   int want;
   // Half period of 25 ns gives the 20 MHz clock.
   always #25 clk = ~clk;
   // Cycle stamps let rate checks ignore the exact bus latency.
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (wd_to === 1'h1) begin
         to_n <= to_n + 1;
      end
   end
   tcsp_top i_dut (
      .CLK_IN(clk),
      .RST_IN(rst),
      .CE_IN(ce),
      .WB_CYC_IN(cyc),
      .WB_STB_IN(stb),
      .WB_WE_IN(we),
      .WB_ADR_IN(adr),
      .WB_SEL_IN(sel),
      .WB_DAT_IN(dat_w),
      .WB_DAT_OUT(dat_r),
      .WB_ACK_OUT(ack),
      .EXT_COUNT_PIN_IN(pin),
      .SLEEP_IN(sleep),
      .WATCHDOG_TICK_IN(wd_tick),
      .WATCHDOG_CLEAR_INSTR_IN(wd_clr),
      .WATCHDOG_TIMEOUT_OUT(wd_to),
      .OVERFLOW_IRQ_OUT(irq)
   );
   tcsp_pin_source i_src (
      .clk_in(clk),
      .pin_out(pin)
   );
   // ****
   // Tasks and expectations
   // ****
   task automatic final_report;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp_v, input string m);
      comparisons++;
      if (got !== exp_v) begin
         failures++;
         $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp_v);
      end
   endtask
   // The request stands until ack is sampled high; a hung slave ends the run.
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      dat_w <= {24'h0, d};
      sel <= 4'h1;
      @(posedge clk);
      t_take = cyc_n;
      while (ack !== 1'h1) begin
         k++;
         if (k > 20) begin
            failures++;
            final_report();
         end
         @(posedge clk);
      end
      q = dat_r;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      sel <= 4'h0;
   endtask
   task automatic pulse_ticks(input int k);
      for (int i = 0; i < k; i++) begin
         @(posedge clk);
         wd_tick <= 1'h1;
         @(posedge clk);
         wd_tick <= 1'h0;
      end
   endtask
   task automatic wd_clear;
      @(posedge clk);
      wd_clr <= 1'h1;
      @(posedge clk);
      wd_clr <= 1'h0;
   endtask
   // Cycles per count step; a negative ratio means the watchdog owns the prescaler.
   function automatic int step_period(input int r);
      return (r < 0) ? 1 : (2 << r);
   endfunction
   // Ticks after a clear until the first watchdog timeout; a symmetric divider rises at half.
   function automatic int first_timeout(input int r);
      return (r == 0) ? 1 : (1 << (r - 1));
   endfunction
   // Selected pin edges produced by n toggles from a starting level.
   function automatic int edges(input logic lvl, input int n, input logic fall);
      int c;
      c = 0;
      for (int i = 0; i < n; i++) begin
         lvl = ~lvl;
         if (lvl != fall) begin
            c++;
         end
      end
      return c;
   endfunction
   // ****
   // Main sequence
   // ****
   initial begin
      seed_v = $urandom(32'h2140);
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
      check(q, 32'h0, "count reset");
      bus(1'h0, `TCSP_IDX_OPTION, 8'h00);
      check(q, 32'hFF, "option reset");
      bus(1'h0, `TCSP_IDX_INTCTL, 8'h00);
      check(q, 32'h0, "intctl reset");
      bus(1'h0, 10'h3FF, 8'h00);
      check(q, 32'h0, "unmapped read");
      wd_clear();
      for (int r = -1; r < 8; r++) begin
         bus(1'h1, `TCSP_IDX_OPTION, (r < 0) ? 8'h08 : 8'(r));
         bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
         t1 = t_take;
         q2 = q;
         repeat (3 * step_period(r) - 3) @(posedge clk);
         bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
         dq = q[7:0] - q2[7:0];
         want = (t_take - t1) / step_period(r);
         check({24'h0, dq}, 32'(want), "count rate");
      end
      v = 8'($urandom);
      repeat (v) @(posedge clk);
      bus(1'h1, `TCSP_IDX_COUNT, v);
      repeat (100) @(posedge clk);
      bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
      check(q, {24'h0, v}, "prescaler clear");
      repeat (40) @(posedge clk);
      bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
      check(q, {24'h0, v + 8'h01}, "first scaled step");
      bus(1'h1, `TCSP_IDX_COUNT, 8'h00);
      bus(1'h1, `TCSP_IDX_OPTION, 8'h0F);
      wd_clear();
      bus(1'h1, `TCSP_IDX_OPTION, 8'h08);
      v = 8'($urandom);
      bus(1'h1, `TCSP_IDX_COUNT, v);
      bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
      check(q, {24'h0, v}, "write hold");
      bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
      check(q, {24'h0, v + 8'h02}, "write resume");
      bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
      t1 = t_take;
      q2 = q;
      ce <= 1'h0;
      repeat (20) @(posedge clk);
      ce <= 1'h1;
      bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
      dq = q[7:0] - q2[7:0];
      check({24'h0, dq}, 32'(t_take - t1 - 20), "enable freeze");
      bus(1'h1, `TCSP_IDX_COUNT, 8'hFD);
      repeat (10) @(posedge clk);
      bus(1'h0, `TCSP_IDX_INTCTL, 8'h00);
      check(q, 32'h04, "flag set");
      check({31'h0, irq}, 32'h0, "irq masked");
      bus(1'h1, `TCSP_IDX_INTCTL, 8'h24);
      @(posedge clk);
      check({31'h0, irq}, 32'h1, "irq raised");
      bus(1'h1, `TCSP_IDX_INTCTL, 8'h04);
      @(posedge clk);
      check({31'h0, irq}, 32'h0, "irq disabled");
      bus(1'h0, `TCSP_IDX_INTCTL, 8'h00);
      check(q, 32'h04, "flag kept");
      bus(1'h1, `TCSP_IDX_INTCTL, 8'h20);
      sleep <= 1'h1;
      bus(1'h1, `TCSP_IDX_COUNT, 8'hFF);
      repeat (40) @(posedge clk);
      bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
      check(q, 32'hFF, "sleep count");
      check({31'h0, irq}, 32'h0, "sleep irq");
      sleep <= 1'h0;
      for (int e = 0; e < 2; e++) begin
         bus(1'h1, `TCSP_IDX_OPTION, (e == 0) ? 8'h28 : 8'h38);
         bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
         q2 = q;
         n = 3 + ($urandom % 8);
         want = edges(pin, n, e[0]);
         i_src.toggles(n);
         repeat (12) @(posedge clk);
         bus(1'h0, `TCSP_IDX_COUNT, 8'h00);
         dq = q[7:0] - q2[7:0];
         check({24'h0, dq}, 32'(want), "pin edges");
      end
      for (int r = 0; r < 4; r++) begin
         bus(1'h1, `TCSP_IDX_OPTION, 8'h08 | 8'(r));
         wd_clear();
         repeat (3) @(posedge clk);
         n = to_n;
         pulse_ticks(first_timeout(r) - 1);
         wd_clear();
         pulse_ticks(first_timeout(r) - 1);
         repeat (3) @(posedge clk);
         check(32'(to_n - n), 32'h0, "early timeout");
         pulse_ticks(1);
         repeat (3) @(posedge clk);
         check(32'(to_n - n), 32'h1, "scaled timeout");
         pulse_ticks((1 << r) - 1);
         repeat (3) @(posedge clk);
         check(32'(to_n - n), 32'h1, "timeout period");
         pulse_ticks(1);
         repeat (3) @(posedge clk);
         check(32'(to_n - n), 32'h2, "second timeout");
      end
      final_report();
   end
endmodule
